// ### verilog/skip_sub_pkg.sv
// constants, types and helpers for the skip, subtract and swap execution block
// Notes on behaviour
// - a bit-test skip skips the next instruction when the chosen bit of the memory byte is one, and leaves every flag alone.
// - a byte skip skips the next instruction when the memory byte is nonzero, else carries on, and leaves every flag alone.
// - a taken skip costs two instruction cycles, the second being a dummy cycle in place of the skipped instruction.
// - subtract-into-working-register puts working register minus memory byte into the working register.
// - on every subtraction carry is cleared when the difference is negative and set when it is zero or positive.
// - every subtraction updates signed range, zero, half borrow, carry, signed chain and chained null flags.
// - subtract-into-memory writes working register minus memory byte back to that same memory byte.
// - subtract-immediate puts working register minus the instruction constant into the working register.
// - nibble exchange swaps bits 3..0 with bits 7..4 of the memory byte in place and touches no flag.
package skip_sub_pkg;

	localparam int DATA_W     = 8;
	localparam int BIT_SEL_W  = 3;
	localparam int NIB_W      = 4;
	localparam int NIB_LO_MSB = 3;
	localparam int NIB_HI_LSB = 4;
	localparam int NIB_HI_MSB = 7;

	localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic              FLAG_RESET = 1'b0;

	typedef enum logic [2:0] {
		OP_NONE        = 3'b000,
		OP_SKIP_BIT    = 3'b001,
		OP_SKIP_BYTE   = 3'b010,
		OP_MINUS_ACC   = 3'b011,
		OP_MINUS_MEM   = 3'b100,
		OP_MINUS_IMM   = 3'b101,
		OP_SWAP_NIBBLE = 3'b110
	} op_t;

	typedef enum logic {
		ST_RUN   = 1'b0,
		ST_DUMMY = 1'b1
	} exec_state_t;

	function automatic logic [DATA_W-1:0] swap_nibbles(input logic [DATA_W-1:0] b);
		swap_nibbles = {b[NIB_LO_MSB:0], b[NIB_HI_MSB:NIB_HI_LSB]};
	endfunction

	function automatic logic is_minus(input op_t op);
		is_minus = (op == OP_MINUS_ACC) || (op == OP_MINUS_MEM) || (op == OP_MINUS_IMM);
	endfunction

	function automatic logic is_skip(input op_t op);
		is_skip = (op == OP_SKIP_BIT) || (op == OP_SKIP_BYTE);
	endfunction

endpackage

// ### verilog/minus_link_if.sv
// operands and results passed between the executor and its subtractor
`timescale 1ns/1ps
`default_nettype none
interface minus_link_if;
	logic [7:0] minuend;
	logic [7:0] subtrahend;
	logic [7:0] diff;
	logic       carry;
	logic       zero;
	logic       signed_range;
	logic       half_borrow;
	logic       signed_chain;
	logic       chained_null;

	modport calc (
		input  minuend,
		input  subtrahend,
		output diff,
		output carry,
		output zero,
		output signed_range,
		output half_borrow,
		output signed_chain,
		output chained_null
	);

	modport user (
		output minuend,
		output subtrahend,
		input  diff,
		input  carry,
		input  zero,
		input  signed_range,
		input  half_borrow,
		input  signed_chain,
		input  chained_null
	);
endinterface
`default_nettype wire

// ### verilog/minus_flags.sv
// eight-bit subtractor with its status flag terms
`timescale 1ns/1ps
`default_nettype none
module minus_flags
	import skip_sub_pkg::*;
(
	minus_link_if.calc lnk
);
	logic [DATA_W:0] full;
	logic [NIB_W:0]  low;

	always_comb begin
		full = {1'b0, lnk.minuend} - {1'b0, lnk.subtrahend};
		low  = {1'b0, lnk.minuend[NIB_LO_MSB:0]} - {1'b0, lnk.subtrahend[NIB_LO_MSB:0]};
	end

	assign lnk.diff         = full[DATA_W-1:0];
	// borrow out of bit 7 means a negative difference
	assign lnk.carry        = ~full[DATA_W];
	assign lnk.zero         = (full[DATA_W-1:0] == ZERO_BYTE);
	// operands of unlike sign and result sign unlike the minuend
	assign lnk.signed_range = (lnk.minuend[DATA_W-1] != lnk.subtrahend[DATA_W-1])
	                          && (full[DATA_W-1] != lnk.minuend[DATA_W-1]);
	assign lnk.half_borrow  = ~low[NIB_W];
	// signed greater-or-equal, same sense as carry
	assign lnk.signed_chain = ~(lnk.signed_range ^ full[DATA_W-1]);
	assign lnk.chained_null = (full[DATA_W-1:0] == ZERO_BYTE);
endmodule
`default_nettype wire

// ### verilog/skip_subtract_swap_exec.sv
// executes byte/bit skip-if-nonzero, three subtractions and nibble swap
`timescale 1ns/1ps
`default_nettype none
module skip_subtract_swap_exec
	import skip_sub_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 op_valid,
	input  wire op_t                  op_code,
	input  wire logic [BIT_SEL_W-1:0] bit_sel,
	input  wire logic [DATA_W-1:0]    imm_value,
	input  wire logic [DATA_W-1:0]    mem_rdata,
	input  wire logic                 wreg_load,
	input  wire logic [DATA_W-1:0]    wreg_load_value,
	output logic                      op_ready,
	output logic                      dummy_cycle,
	output logic                      mem_we,
	output logic [DATA_W-1:0]         mem_wdata,
	output logic [DATA_W-1:0]         working_register,
	output logic                      carry_flag,
	output logic                      zero_flag,
	output logic                      signed_range_flag,
	output logic                      half_borrow_flag,
	output logic                      signed_chain_flag,
	output logic                      chained_null_flag
);

	// ************************************************************
	// issue and operand selection
	// ************************************************************
	exec_state_t state_reg;
	exec_state_t state_next;
	logic        accept;
	logic        skip_taken;
	logic        minus_op;

	minus_link_if lnk ();

	minus_flags u_minus (
		.lnk (lnk.calc)
	);

	// an instruction is taken only while no dummy cycle is pending
	assign accept   = op_valid && op_ready;
	assign minus_op = is_minus(op_code);

	assign lnk.minuend    = working_register;
	assign lnk.subtrahend = (op_code == OP_MINUS_IMM) ? imm_value : mem_rdata;

	always_comb begin
		case (op_code)
			OP_SKIP_BIT:  skip_taken = mem_rdata[bit_sel];
			OP_SKIP_BYTE: skip_taken = (mem_rdata != ZERO_BYTE);
			default:      skip_taken = 1'b0;
		endcase
	end

	// ************************************************************
	// skip sequencing
	// ************************************************************
	always_comb begin
		case (state_reg)
			ST_RUN:   state_next = (accept && skip_taken) ? ST_DUMMY : ST_RUN;
			ST_DUMMY: state_next = ST_RUN;
			default:  state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= ST_RUN;
			op_ready    <= 1'b0;
			dummy_cycle <= 1'b0;
		end else begin
			state_reg   <= state_next;
			// dummy cycle replaces the skipped instruction
			op_ready    <= (state_next == ST_RUN);
			dummy_cycle <= (state_next == ST_DUMMY);
		end
	end

	// ************************************************************
	// working register
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			working_register <= WREG_RESET;
		end else if (accept && ((op_code == OP_MINUS_ACC) || (op_code == OP_MINUS_IMM))) begin
			working_register <= lnk.diff;
		end else if (wreg_load && !(accept && minus_op)) begin
			working_register <= wreg_load_value;
		end
	end

	// ************************************************************
	// data memory write-back
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_we    <= 1'b0;
			mem_wdata <= ZERO_BYTE;
		end else begin
			mem_we <= accept && ((op_code == OP_MINUS_MEM) || (op_code == OP_SWAP_NIBBLE));
			if (accept && (op_code == OP_MINUS_MEM)) begin
				mem_wdata <= lnk.diff;
			end else if (accept && (op_code == OP_SWAP_NIBBLE)) begin
				mem_wdata <= swap_nibbles(mem_rdata);
			end
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	// skips and swaps leave every flag as it was
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			carry_flag        <= FLAG_RESET;
			zero_flag         <= FLAG_RESET;
			signed_range_flag <= FLAG_RESET;
			half_borrow_flag  <= FLAG_RESET;
			signed_chain_flag <= FLAG_RESET;
			chained_null_flag <= FLAG_RESET;
		end else if (accept && minus_op) begin
			carry_flag        <= lnk.carry;
			zero_flag         <= lnk.zero;
			signed_range_flag <= lnk.signed_range;
			half_borrow_flag  <= lnk.half_borrow;
			signed_chain_flag <= lnk.signed_chain;
			chained_null_flag <= lnk.chained_null;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	logic [5:0]        flag_vec;
	logic [DATA_W-1:0] exp_sub;
	logic              exp_ge;
	logic              exp_ovf;

	assign flag_vec = {carry_flag, zero_flag, signed_range_flag,
	                   half_borrow_flag, signed_chain_flag, chained_null_flag};
	assign exp_sub  = working_register - lnk.subtrahend;
	assign exp_ge   = (working_register >= lnk.subtrahend);
	assign exp_ovf  = ($signed(working_register) - $signed(lnk.subtrahend) > 127)
	                  || ($signed(working_register) - $signed(lnk.subtrahend) < -128);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_bit_skip;
		accept && (op_code == OP_SKIP_BIT)
		|=> (dummy_cycle == $past(mem_rdata[bit_sel])) && $stable(flag_vec);
	endproperty
	a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

	property p_byte_skip;
		accept && (op_code == OP_SKIP_BYTE)
		|=> (dummy_cycle == ($past(mem_rdata) != ZERO_BYTE)) && $stable(flag_vec) && !mem_we;
	endproperty
	a_byte_skip: assert property (p_byte_skip) else $error("byte skip wrong");

	property p_two_cycles;
		accept && skip_taken |=> !op_ready ##1 op_ready && !dummy_cycle;
	endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("skip not two cycles");

	property p_minus_acc;
		accept && (op_code == OP_MINUS_ACC) |=> working_register == $past(exp_sub) && !mem_we;
	endproperty
	a_minus_acc: assert property (p_minus_acc) else $error("acc subtract wrong");

	property p_carry;
		accept && minus_op |=> carry_flag == $past(exp_ge);
	endproperty
	a_carry: assert property (p_carry) else $error("carry wrong");

	property p_zero_pair;
		accept && minus_op
		|=> (zero_flag == ($past(exp_sub) == ZERO_BYTE)) && (chained_null_flag == zero_flag);
	endproperty
	a_zero_pair: assert property (p_zero_pair) else $error("zero flags wrong");

	property p_minus_mem;
		accept && (op_code == OP_MINUS_MEM)
		|=> mem_we && (mem_wdata == $past(exp_sub)) && $stable(working_register);
	endproperty
	a_minus_mem: assert property (p_minus_mem) else $error("memory subtract wrong");

	property p_minus_imm;
		accept && (op_code == OP_MINUS_IMM)
		|=> working_register == 8'($past(working_register) - $past(imm_value));
	endproperty
	a_minus_imm: assert property (p_minus_imm) else $error("immediate subtract wrong");

	property p_swap;
		accept && (op_code == OP_SWAP_NIBBLE)
		|=> mem_we && (mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
		    && $stable(flag_vec) ##1 !mem_we || (mem_we && $past(accept));
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");

	property p_overflow;
		accept && minus_op |=> signed_range_flag == $past(exp_ovf);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

	// judged on the operands, so a swapped borrow sense in the subtractor shows up
	property p_half_borrow;
		accept && minus_op
		|=> half_borrow_flag == ($past(working_register[NIB_LO_MSB:0])
		                         >= $past(lnk.subtrahend[NIB_LO_MSB:0]));
	endproperty
	a_half_borrow: assert property (p_half_borrow) else $error("half borrow flag wrong");

	property p_signed_chain;
		accept && minus_op
		|=> signed_chain_flag == ($signed($past(working_register))
		                          >= $signed($past(lnk.subtrahend)));
	endproperty
	a_signed_chain: assert property (p_signed_chain) else $error("signed chain flag wrong");

	// an instruction offered during the dummy slot must leave no trace
	property p_refused;
		op_valid && !op_ready
		|=> !mem_we && !dummy_cycle && $stable(flag_vec);
	endproperty
	a_refused: assert property (p_refused) else $error("refused instruction acted");

	property p_dummy_one;
		dummy_cycle |=> !dummy_cycle && op_ready;
	endproperty
	a_dummy_one: assert property (p_dummy_one) else $error("dummy slot too long");

	c_skip_taken: cover property (accept && skip_taken ##1 dummy_cycle ##1 op_ready);
	c_borrow:     cover property (accept && minus_op ##1 !carry_flag);
	c_mem_write:  cover property (accept && (op_code == OP_MINUS_MEM) ##1 mem_we);
	c_swap:       cover property (accept && (op_code == OP_SWAP_NIBBLE) ##1 mem_we);

endmodule
`default_nettype wire

// ### sim/data_mem_model.sv
// behavioural data memory byte standing behind the executor
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
	input  wire logic       ref_clk,
	input  wire logic       preset,
	input  wire logic [7:0] preset_value,
	input  wire logic       mem_we,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata
);
	// the address is held outside, so one byte stands for the addressed place
	initial mem_rdata = 8'h00;
	always @(posedge ref_clk) begin
		if (preset) begin
			mem_rdata <= preset_value;
		end else if (mem_we) begin
			mem_rdata <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

// ### sim/skip_subtract_swap_exec_bench.sv
// self-checking bench for the skip, subtract and swap executor
`timescale 1ns/1ps
`default_nettype none
module skip_subtract_swap_exec_bench import skip_sub_pkg::*;;
	logic                 ref_clk, nrst, op_valid, wreg_load, preset, op_ready, dummy_cycle, mem_we;
	op_t                  op_code;
	logic [BIT_SEL_W-1:0] bit_sel;
	logic [DATA_W-1:0]    imm_value, mem_rdata, wreg_load_value, preset_value, mem_wdata;
	logic [DATA_W-1:0]    working_register;
	logic                 carry_flag, zero_flag, signed_range_flag;
	logic                 half_borrow_flag, signed_chain_flag, chained_null_flag;
	logic [5:0]           flags;
	int                   errors, compares;

	assign flags = {carry_flag, zero_flag, signed_range_flag,
		half_borrow_flag, signed_chain_flag, chained_null_flag};

	skip_subtract_swap_exec i_skip_subtract_swap_exec (.ref_clk(ref_clk), .nrst(nrst),
		.op_valid(op_valid), .op_code(op_code), .bit_sel(bit_sel), .imm_value(imm_value),
		.mem_rdata(mem_rdata), .wreg_load(wreg_load), .wreg_load_value(wreg_load_value),
		.op_ready(op_ready), .dummy_cycle(dummy_cycle), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .working_register(working_register), .carry_flag(carry_flag),
		.zero_flag(zero_flag), .signed_range_flag(signed_range_flag),
		.half_borrow_flag(half_borrow_flag), .signed_chain_flag(signed_chain_flag),
		.chained_null_flag(chained_null_flag));

	data_mem_model i_data_mem_model (.ref_clk(ref_clk), .preset(preset),
		.preset_value(preset_value), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));

	// ****************
	// checking helpers
	// ****************
	// flags worked out from signed and unsigned arithmetic, not from the borrow terms
	function automatic logic [5:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
		logic [7:0]        d;
		logic signed [8:0] s;
		logic              ov;
		d = a - b;
		s = $signed({a[7], a}) - $signed({b[7], b});
		ov = (s > 9'sh07F) || (s < -9'sh080);
		exp_flags = {a >= b, d == ZERO_BYTE, ov, a[3:0] >= b[3:0],
			$signed(a) >= $signed(b), d == ZERO_BYTE};
	endfunction

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk6(input string n, input logic [5:0] e, input logic [5:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic finish_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****************
	// stimulus tasks
	// ****************
	// presets both the working register and the memory byte in one cycle
	task automatic setup(input logic [7:0] w, input logic [7:0] m);
		@(posedge ref_clk);
		wreg_load <= 1'b1;
		wreg_load_value <= w;
		preset <= 1'b1;
		preset_value <= m;
		@(posedge ref_clk);
		wreg_load <= 1'b0;
		preset <= 1'b0;
	endtask

	// results are looked at 1 ns after the taking edge, their only cycle
	task automatic issue(input op_t op, input logic [2:0] b, input logic [7:0] x);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= op;
		bit_sel <= b;
		imm_value <= x;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic t_sub_acc(input logic [7:0] a, input logic [7:0] m);
		setup(a, m);
		issue(OP_MINUS_ACC, 3'h0, 8'h00);
		chk8("wreg", a - m, working_register);
		chk6("flags", exp_flags(a, m), flags);
	endtask

	task automatic t_sub_imm(input logic [7:0] a, input logic [7:0] x);
		setup(a, 8'hC3);
		issue(OP_MINUS_IMM, 3'h0, x);
		chk8("wreg", a - x, working_register);
		chk6("flags", exp_flags(a, x), flags);
	endtask

	task automatic t_sub_mem(input logic [7:0] a, input logic [7:0] m);
		setup(a, m);
		issue(OP_MINUS_MEM, 3'h0, 8'h00);
		chk1("mem_we", 1'b1, mem_we);
		chk8("mem_wdata", a - m, mem_wdata);
		chk8("wreg", a, working_register);
		chk6("flags", exp_flags(a, m), flags);
		@(posedge ref_clk);
		#1;
		chk1("mem_we", 1'b0, mem_we);
		chk8("mem", a - m, mem_rdata);
	endtask

	task automatic t_swap(input logic [7:0] m);
		logic [5:0] f;
		setup(8'h33, m);
		f = flags;
		issue(OP_SWAP_NIBBLE, 3'h0, 8'h00);
		chk1("mem_we", 1'b1, mem_we);
		chk8("mem_wdata", {m[3:0], m[7:4]}, mem_wdata);
		chk6("flags", f, flags);
		chk8("wreg", 8'h33, working_register);
		@(posedge ref_clk);
		#1;
		chk1("mem_we", 1'b0, mem_we);
		chk8("mem", {m[3:0], m[7:4]}, mem_rdata);
	endtask

	task automatic t_skip(input op_t op, input logic [7:0] m, input logic [2:0] b, input logic s);
		logic [5:0] f;
		setup(8'h44, m);
		f = flags;
		issue(op, b, 8'h00);
		chk1("dummy", s, dummy_cycle);
		chk1("ready", !s, op_ready);
		chk6("flags", f, flags);
		chk8("wreg", 8'h44, working_register);
		@(posedge ref_clk);
		#1;
		chk1("dummy", 1'b0, dummy_cycle);
		chk1("ready", 1'b1, op_ready);
	endtask

	// two subtractions on consecutive edges, the second reading the first's result
	task automatic t_chain(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
		setup(a, m);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= OP_MINUS_IMM;
		imm_value <= x;
		@(posedge ref_clk);
		op_code <= OP_MINUS_ACC;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		chk8("wreg", a - x - m, working_register);
		chk6("flags", exp_flags(a - x, m), flags);
	endtask

	// a memory subtraction offered in the dummy slot after a taken skip is ignored
	task automatic t_refused;
		logic [5:0] f;
		setup(8'h44, 8'h05);
		f = flags;
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= OP_SKIP_BYTE;
		@(posedge ref_clk);
		op_code <= OP_MINUS_MEM;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		chk1("mem_we", 1'b0, mem_we);
		chk8("wreg", 8'h44, working_register);
		chk6("flags", f, flags);
		chk1("ready", 1'b1, op_ready);
		@(posedge ref_clk);
		#1;
		chk8("mem", 8'h05, mem_rdata);
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		#200000;
		errors++;
		finish_test;
	end

	initial begin
		errors = 0;
		compares = 0;
		nrst = 1'b0;
		{op_valid, wreg_load, preset} = 3'b000;
		op_code = OP_NONE;
		bit_sel = 3'h0;
		imm_value = 8'h00;
		wreg_load_value = 8'h00;
		preset_value = 8'h00;
		repeat (8) @(posedge ref_clk);
		chk1("ready", 1'b0, op_ready);
		chk8("wreg", WREG_RESET, working_register);
		nrst <= 1'b1;
		@(posedge ref_clk);
		t_sub_acc(8'h20, 8'h20);
		t_sub_acc(8'h10, 8'h20);
		t_sub_acc(8'h80, 8'h01);
		t_sub_acc(8'h7F, 8'hFF);
		t_sub_imm(8'h35, 8'h17);
		t_sub_imm(8'h00, 8'h01);
		t_sub_mem(8'h10, 8'h20);
		t_sub_mem(8'h9C, 8'h1D);
		t_swap(8'hA5);
		t_skip(OP_SKIP_BYTE, 8'h05, 3'h0, 1'b1);
		t_skip(OP_SKIP_BYTE, 8'h00, 3'h0, 1'b0);
		t_skip(OP_SKIP_BIT, 8'h80, 3'h7, 1'b1);
		t_skip(OP_SKIP_BIT, 8'h7F, 3'h7, 1'b0);
		t_skip(OP_SKIP_BIT, 8'hFE, 3'h0, 1'b0);
		t_skip(OP_NONE, 8'hFF, 3'h0, 1'b0);
		t_chain(8'h08, 8'h09, 8'h01);
		t_refused;
		finish_test;
	end
endmodule
`default_nettype wire
